/* include/sad_pkg.sv */
/*
 * Shared definitions of the system address decoder: the region map,
 * the populated memory sizes, region and error encodings, and the
 * request and response carriers.
 * Assumes a 32-bit byte-addressed system bus with one request per cycle.
 */
package sad_pkg;

   localparam int ADDR_WIDTH = 32;

   // Region codes; the first seven have select lines, all but SAD_EXT_DEVICE with a real target
   typedef enum logic [2:0] {
      SAD_CODE        = 3'h0,
      SAD_SRAM        = 3'h1,
      SAD_PERIPHERAL  = 3'h2,
      SAD_SERIAL_MEM  = 3'h3,
      SAD_EXT_DEVICE  = 3'h4,
      SAD_PRIVATE_BUS = 3'h5,
      SAD_SYSTEM      = 3'h6,
      SAD_UNMAPPED    = 3'h7
   } sad_region_type;

   localparam int TARGET_COUNT = 7;

   // Region bounds, inclusive
   localparam logic [31:0] CODE_BASE        = 32'h0000_0000;
   localparam logic [31:0] CODE_LAST        = 32'h1FFF_FFFF;
   localparam logic [31:0] SRAM_BASE        = 32'h2000_0000;
   localparam logic [31:0] SRAM_LAST        = 32'h3FFF_FFFF;
   localparam logic [31:0] PERIPHERAL_BASE  = 32'h4000_0000;
   localparam logic [31:0] PERIPHERAL_LAST  = 32'h5FFF_FFFF;
   localparam logic [31:0] SERIAL_MEM_BASE  = 32'h6000_0000;
   localparam logic [31:0] SERIAL_MEM_LAST  = 32'h8FFF_FFFF;
   localparam logic [31:0] EXT_DEVICE_BASE  = 32'hA000_0000;
   localparam logic [31:0] EXT_DEVICE_LAST  = 32'hDFFF_FFFF;
   localparam logic [31:0] PRIVATE_BUS_BASE = 32'hE000_0000;
   localparam logic [31:0] PRIVATE_BUS_LAST = 32'hE00F_FFFF;
   localparam logic [31:0] SYSTEM_LAST      = 32'hFFFF_FFFF;

   // Populated sizes and the lowest legal start of system registers
   localparam logic [31:0] ROM_BASE            = 32'h0000_0000;
   localparam logic [31:0] ROM_SIZE_DEFAULT    = 32'h0001_0000;
   localparam logic [31:0] RAM_SIZE_DEFAULT    = 32'h0004_0000;
   localparam logic [31:0] SYSTEM_BASE_MIN     = 32'hE010_0000;
   localparam logic [31:0] SYSTEM_BASE_DEFAULT = 32'hE010_0000;

   // Access width; byte, halfword and word are legal, SAD_WIDE is refused
   typedef enum logic [1:0] {
      SAD_BYTE = 2'h0,
      SAD_HALF = 2'h1,
      SAD_WORD = 2'h2,
      SAD_WIDE = 2'h3
   } sad_size_type;

   // Reason for a bus error answer
   typedef enum logic [2:0] {
      SAD_CAUSE_NONE     = 3'h0,
      SAD_CAUSE_UNMAPPED = 3'h1,
      SAD_CAUSE_HOLE     = 3'h2,
      SAD_CAUSE_FETCH    = 3'h3,
      SAD_CAUSE_SIZE     = 3'h4
   } sad_cause_type;

   localparam int ERROR_COUNT_WIDTH = 8;

   typedef struct packed {
      logic         valid;
      logic [31:0]  addr;
      logic         fetch;
      logic         write;
      sad_size_type size;
   } sad_request_type;

   typedef struct packed {
      logic           valid;
      logic           error;
      sad_region_type region;
      sad_cause_type  cause;
      logic [31:0]    offset;
      logic [31:0]    addr;
      logic           fetch;
      logic           write;
      sad_size_type   size;
   } sad_response_type;

endpackage

/* hdl/sad_region_lookup.sv */
/*
 * Combinational region lookup: region, hole and execute permission
 * of one address, plus its offset from the base of any region with a target.
 * Assumes the parameters were checked by the instantiating module.
 */
module sad_region_lookup #(
   parameter logic [31:0] ROM_SIZE    = sad_pkg::ROM_SIZE_DEFAULT,
   parameter logic [31:0] RAM_SIZE    = sad_pkg::RAM_SIZE_DEFAULT,
   parameter logic [31:0] SYSTEM_BASE = sad_pkg::SYSTEM_BASE_DEFAULT
) (
   input  wire logic [31:0]             addr,
   output sad_pkg::sad_region_type      region,
   output logic                         in_hole,
   output logic                         exec_allowed,
   output logic [31:0]                  offset
);

   // Inclusive range test, used for every region
   function automatic logic in_range(input logic [31:0] a,
                                     input logic [31:0] base,
                                     input logic [31:0] last);
      in_range = (a >= base) && (a <= last);
   endfunction

   // Upper address bits pick exactly one region
   always_comb begin
      region = sad_pkg::SAD_UNMAPPED;
      if (in_range(addr, sad_pkg::CODE_BASE, sad_pkg::CODE_LAST)) begin
         region = sad_pkg::SAD_CODE;
      end else if (in_range(addr, sad_pkg::SRAM_BASE,
                            sad_pkg::SRAM_LAST)) begin
         region = sad_pkg::SAD_SRAM;
      end else if (in_range(addr, sad_pkg::PERIPHERAL_BASE,
                            sad_pkg::PERIPHERAL_LAST)) begin
         region = sad_pkg::SAD_PERIPHERAL;
      end else if (in_range(addr, sad_pkg::SERIAL_MEM_BASE,
                            sad_pkg::SERIAL_MEM_LAST)) begin
         region = sad_pkg::SAD_SERIAL_MEM;
      end else if (in_range(addr, sad_pkg::EXT_DEVICE_BASE,
                            sad_pkg::EXT_DEVICE_LAST)) begin
         region = sad_pkg::SAD_EXT_DEVICE;
      end else if (in_range(addr, sad_pkg::PRIVATE_BUS_BASE,
                            sad_pkg::PRIVATE_BUS_LAST)) begin
         region = sad_pkg::SAD_PRIVATE_BUS;
      end else if (in_range(addr, SYSTEM_BASE,
                            sad_pkg::SYSTEM_LAST)) begin
         region = sad_pkg::SAD_SYSTEM;
      end
   end

   // Holes past the populated ROM and RAM
   always_comb begin
      in_hole = 1'b0;
      case (region)
         sad_pkg::SAD_CODE: in_hole = (addr - sad_pkg::ROM_BASE)
                                      >= ROM_SIZE;
         sad_pkg::SAD_SRAM: in_hole = (addr - sad_pkg::SRAM_BASE)
                                      >= RAM_SIZE;
         default:           in_hole = 1'b0;
      endcase
   end

   // Only code, RAM and serial memory may hold instructions
   always_comb begin
      case (region)
         sad_pkg::SAD_CODE,
         sad_pkg::SAD_SRAM,
         sad_pkg::SAD_SERIAL_MEM: exec_allowed = 1'b1;
         default:                 exec_allowed = 1'b0;
      endcase
   end

   // Offset from the region base, raw address when unmapped or in the external device region
   always_comb begin
      case (region)
         sad_pkg::SAD_CODE:        offset = addr - sad_pkg::CODE_BASE;
         sad_pkg::SAD_SRAM:        offset = addr - sad_pkg::SRAM_BASE;
         sad_pkg::SAD_PERIPHERAL:  offset = addr - sad_pkg::PERIPHERAL_BASE;
         sad_pkg::SAD_SERIAL_MEM:  offset = addr - sad_pkg::SERIAL_MEM_BASE;
         sad_pkg::SAD_PRIVATE_BUS: offset = addr - sad_pkg::PRIVATE_BUS_BASE;
         sad_pkg::SAD_SYSTEM:      offset = addr - SYSTEM_BASE;
         default:                  offset = addr;
      endcase
   end

endmodule

/* hdl/sad_decoder.sv */
/*
 * System address decoder: sorts each bus request into one target
 * region, checks fetch permission and access width, and answers with
 * a registered target select or a bus error, one cycle later.
 * Assumes requests come from logic on the same clock, at most one per
 * cycle, and that the selected target does the actual data transfer.
 */
module sad_decoder #(
   parameter logic [31:0] ROM_SIZE    = sad_pkg::ROM_SIZE_DEFAULT,
   parameter logic [31:0] RAM_SIZE    = sad_pkg::RAM_SIZE_DEFAULT,
   parameter logic [31:0] SYSTEM_BASE = sad_pkg::SYSTEM_BASE_DEFAULT
) (
   input  wire logic                                    clock,
   input  wire logic                                    reset,
   input  wire logic                                    enable,
   input  wire sad_pkg::sad_request_type                request,
   output sad_pkg::sad_response_type                    response,
   output logic [sad_pkg::TARGET_COUNT-1:0]             target_select,
   output logic [31:0]                                  error_address,
   output sad_pkg::sad_cause_type                       error_cause,
   output logic                                         error_fetch,
   output logic [sad_pkg::ERROR_COUNT_WIDTH-1:0]        error_count
);

   // Refuse sizes that break the hole test or overlap other regions
   if (ROM_SIZE == 32'h0000_0000 ||
       ROM_SIZE > (sad_pkg::CODE_LAST - sad_pkg::CODE_BASE)) begin : g_rom
      $error("ROM size must be nonzero and fit the code region");
   end
   if (RAM_SIZE == 32'h0000_0000 ||
       RAM_SIZE > (sad_pkg::SRAM_LAST - sad_pkg::SRAM_BASE)) begin : g_ram
      $error("RAM size must be nonzero and fit the SRAM region");
   end
   if (SYSTEM_BASE < sad_pkg::SYSTEM_BASE_MIN) begin : g_sys
      $error("System register base overlaps the private bus");
   end

   // Decoded view of the incoming address
   sad_pkg::sad_region_type decoded_region;
   logic                    decoded_hole;
   logic                    decoded_exec;
   logic [31:0]             decoded_offset;

   // Verdict for the incoming request
   logic                    next_error;
   sad_pkg::sad_cause_type  next_cause;
   logic [sad_pkg::TARGET_COUNT-1:0] next_target_select;

   sad_region_lookup #(
      .ROM_SIZE    (ROM_SIZE),
      .RAM_SIZE    (RAM_SIZE),
      .SYSTEM_BASE (SYSTEM_BASE)
   ) u_lookup (
      .addr         (request.addr),
      .region       (decoded_region),
      .in_hole      (decoded_hole),
      .exec_allowed (decoded_exec),
      .offset       (decoded_offset)
   );

   // A region with a real target behind it
   function automatic logic has_target(input sad_pkg::sad_region_type r);
      case (r)
         sad_pkg::SAD_EXT_DEVICE,
         sad_pkg::SAD_UNMAPPED: has_target = 1'b0;
         default:               has_target = 1'b1;
      endcase
   endfunction

   // Error verdict; address faults outrank fetch and width faults
   always_comb begin
      next_error = 1'b0;
      next_cause = sad_pkg::SAD_CAUSE_NONE;
      if (!has_target(decoded_region)) begin
         next_error = 1'b1;
         next_cause = sad_pkg::SAD_CAUSE_UNMAPPED;
      end else if (decoded_hole) begin
         next_error = 1'b1;
         next_cause = sad_pkg::SAD_CAUSE_HOLE;
      end else if (request.fetch && !decoded_exec) begin
         next_error = 1'b1;
         next_cause = sad_pkg::SAD_CAUSE_FETCH;
      end else if (request.size == sad_pkg::SAD_WIDE) begin
         // No alias or wide form exists, so refuse it outright
         next_error = 1'b1;
         next_cause = sad_pkg::SAD_CAUSE_SIZE;
      end
   end

   // One select line per target, never more than one high
   for (genvar i = 0; i < sad_pkg::TARGET_COUNT; i++) begin : g_select
      assign next_target_select[i] = request.valid && !next_error &&
         (decoded_region == sad_pkg::sad_region_type'(i));
   end

   // Registered target select, held while the clock enable is low
   always_ff @(posedge clock) begin
      if (reset) begin
         target_select <= '0;
      end else if (enable) begin
         target_select <= next_target_select;
      end
   end

   // Answer to the master, one cycle after the request
   always_ff @(posedge clock) begin
      if (reset) begin
         response <= '0;
      end else if (enable) begin
         response.valid  <= request.valid;
         response.error  <= request.valid && next_error;
         response.region <= decoded_region;
         response.cause  <= next_cause;
         response.offset <= decoded_offset;
         // Address and width pass untouched: no bit alias rewrite
         response.addr   <= request.addr;
         response.fetch  <= request.fetch;
         response.write  <= request.write;
         response.size   <= request.size;
      end
   end

   // Fault log of the most recent refused access
   always_ff @(posedge clock) begin
      if (reset) begin
         error_address <= '0;
         error_cause   <= sad_pkg::SAD_CAUSE_NONE;
         error_fetch   <= 1'b0;
      end else if (enable && request.valid && next_error) begin
         error_address <= request.addr;
         error_cause   <= next_cause;
         error_fetch   <= request.fetch;
      end
   end

   // Saturating fault count; wrapping would hide a flood of faults
   always_ff @(posedge clock) begin
      if (reset) begin
         error_count <= '0;
      end else if (enable && request.valid && next_error &&
                   error_count != '1) begin
         error_count <= error_count + 1'b1;
      end
   end

endmodule

/* testbench/sad_decoder_props.sv */
/* Port checker of the system address decoder.
   Assumes it is bound into sad_decoder and sees its ports only. */
module sad_decoder_props #(
   parameter logic [31:0] ROM_SIZE    = sad_pkg::ROM_SIZE_DEFAULT,
   parameter logic [31:0] RAM_SIZE    = sad_pkg::RAM_SIZE_DEFAULT,
   parameter logic [31:0] SYSTEM_BASE = sad_pkg::SYSTEM_BASE_DEFAULT
) (
   input wire logic                      clock,
   input wire logic                      reset,
   input wire logic                      enable,
   input wire sad_pkg::sad_request_type  request,
   input wire sad_pkg::sad_response_type response,
   input wire logic [6:0]                target_select,
   input wire logic [31:0]               error_address,
   input wire sad_pkg::sad_cause_type    error_cause,
   input wire logic                      error_fetch,
   input wire logic [7:0]                error_count
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // Taken request and a plain access shortcut
   wire logic        taken = enable && request.valid;
   wire logic        plain = taken && request.size != sad_pkg::SAD_WIDE;
   wire logic [31:0] a     = request.addr;

   answer_once_a: assert property (taken |=> response.valid &&
      (response.error ? target_select == 7'h00 : $onehot(target_select)))
      else $error("request not answered once");
   code_hit_a: assert property (plain && a < ROM_SIZE |=>
      target_select == 7'h01 && response.offset == response.addr)
      else $error("code request misrouted");
   sram_hit_a: assert property (plain && a >= 32'h2000_0000
      && a - 32'h2000_0000 < RAM_SIZE |=> target_select == 7'h02)
      else $error("sram request misrouted");
   fetch_block_a: assert property (taken && request.fetch
      && a[31:29] == 3'h2 |=> response.error
      && response.cause == sad_pkg::SAD_CAUSE_FETCH)
      else $error("peripheral fetch not refused");
   serial_exec_a: assert property (plain && a >= 32'h6000_0000
      && a <= 32'h8FFF_FFFF |=> target_select == 7'h08)
      else $error("serial memory request misrouted");
   ext_unused_a: assert property (taken && a >= 32'hA000_0000
      && a <= 32'hDFFF_FFFF |=> response.error
      && response.region == sad_pkg::SAD_EXT_DEVICE)
      else $error("unused device space answered");
   private_bus_a: assert property (plain && !request.fetch
      && a[31:20] == 12'hE00 |=> target_select == 7'h20)
      else $error("private bus request misrouted");
   rom_hole_a: assert property (taken && a < 32'h2000_0000
      && a >= ROM_SIZE |=> response.cause == sad_pkg::SAD_CAUSE_HOLE)
      else $error("rom hole not refused");
   fault_log_a: assert property (response.valid && response.error
      |-> error_address == response.addr && error_fetch == response.fetch)
      else $error("fault log not updated");
   // Main scenarios reached
   cover property (taken && request.fetch);
   cover property (taken ##1 taken);
   cover property (response.valid && response.error);
endmodule

bind sad_decoder sad_decoder_props #(.ROM_SIZE(ROM_SIZE),
   .RAM_SIZE(RAM_SIZE), .SYSTEM_BASE(SYSTEM_BASE)) i_sad_decoder_props (
   .clock, .reset, .enable, .request, .response, .target_select,
   .error_address, .error_cause, .error_fetch, .error_count);

/* testbench/sad_master_model.sv */
/* Bus master model: one decoder request per call.
   Assumes the bench calls its tasks; it drives after falling edges. */
module sad_master_model (
   input wire logic                 clock,
   output sad_pkg::sad_request_type request
);
   timeunit 1ns;
   timeprecision 1ns;
   initial request = '0;
   // Request held a whole cycle so the rising edge sees it settled
   task automatic issue(input logic [31:0] a, input logic f,
                        input logic [1:0] s);
      @(negedge clock);
      request <= '{1'b1, a, f, a[2], sad_pkg::sad_size_type'(s)};
   endtask
   // Released bus shows inverted address and fetch lines; write and size keep the stale request
   task automatic idle();
      @(negedge clock);
      request.valid <= 1'b0;
      request.addr <= ~request.addr;
      request.fetch <= ~request.fetch;
   endtask
endmodule

/* testbench/testbench.sv */
/* Self-checking bench of the system address decoder.
   Assumes one 100 ns clock; inputs change at the falling edge. */
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic                      clock = 1'b0;
   logic                      reset = 1'b1;
   logic                      enable = 1'b1;
   sad_pkg::sad_request_type  request;
   sad_pkg::sad_response_type response;
   logic [6:0]                target_select;
   logic [31:0]               error_address;
   sad_pkg::sad_cause_type    error_cause;
   logic                      error_fetch;
   logic [7:0]                error_count;
   logic [7:0]                exp_count = 8'h00;
   int                        fail_count = 0;
   int                        checked = 0;
   int                        cycles = 0;

   always #50 clock = ~clock;

   sad_decoder i_sad_decoder (.clock, .reset, .enable, .request,
      .response, .target_select, .error_address, .error_cause,
      .error_fetch, .error_count);
   sad_master_model i_sad_master_model (.clock, .request);

   task automatic check(input logic [39:0] seen, input logic [39:0] want);
      checked++;
      if (seen !== want) begin
         fail_count++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, want);
      end
   endtask

   task automatic wrap_up();
      $display("checked %0d, fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Hang guard; the run needs under 100 cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 1000) begin
         fail_count++;
         wrap_up();
      end
   end

   // One request, judged just after the edge that takes it
   task automatic probe(input logic [31:0] a, input logic f,
                        input logic [1:0] s, input logic [2:0] r, c);
      i_sad_master_model.issue(a, f, s);
      @(posedge clock);
      #1;
      if (c != 3'h0 && exp_count != 8'hFF) exp_count++;
      check({response.valid, response.region}, {1'b1, r});
      check(response.cause, c);
      check(target_select, c != 3'h0 ? 7'h00 : 7'h01 << r);
      check(error_count, exp_count);
      if (c != 3'h0) check({error_fetch, error_address}, {f, a});
      if (c != 3'h0) check(error_cause, c);
   endtask

   // Region edges, holes and fetch rights, back to back
   task automatic t_map();
      logic [31:0] a [16] = '{32'h0000_0000, 32'h0000_FFFF, 32'h0001_0000,
         32'h2000_0000, 32'h2003_FFFF, 32'h2004_0000, 32'h5FFF_FFFF,
         32'h8FFF_FFFF, 32'h9000_0000, 32'hDFFF_FFFF, 32'hE00F_FFFF,
         32'hE010_0000, 32'h6000_0100, 32'h4000_0000, 32'hE000_0000,
         32'hFFFF_FFFF};
      logic [6:0] frc [16] = '{7'h40, 7'h00, 7'h02, 7'h48, 7'h08,
         7'h0A, 7'h10, 7'h18, 7'h39, 7'h21, 7'h28, 7'h30,
         7'h58, 7'h53, 7'h6B, 7'h73};
      for (int i = 0; i < 16; i++) begin
         probe(a[i], frc[i][6], 2'h2, frc[i][5:3], frc[i][2:0]);
      end
      i_sad_master_model.idle();
      @(posedge clock);
      #1;
      check(response.valid, 1'b0);
   endtask

   // Every access width, wide ones refused with no alias
   task automatic t_size();
      for (int i = 0; i < 4; i++) begin
         probe(32'h2000_0010, 1'b0, 2'(i), 3'h1,
               i == 3 ? 3'h4 : 3'h0);
         check(response.offset, 32'h0000_0010);
         // Address, write flag and width must pass untouched
         check({response.addr, response.write, response.size},
               {32'h2000_0010, 1'b0, 2'(i)});
      end
      probe(32'h4000_0004, 1'b0, 2'h3, 3'h2, 3'h4);
      probe(32'h4000_0004, 1'b0, 2'h0, 3'h2, 3'h0);
   endtask

   // Enable low freezes the decoder while a bad request waits
   task automatic t_enable();
      i_sad_master_model.idle();
      @(negedge clock);
      enable = 1'b0;
      i_sad_master_model.issue(32'hA000_0000, 1'b0, 2'h2);
      @(posedge clock);
      #1;
      // Frozen answer still shows the idle cycle, count unchanged
      check({response.valid, error_count}, {1'b0, exp_count});
      @(negedge clock);
      enable = 1'b1;
      exp_count++;
      @(posedge clock);
      #1;
      check({response.error, error_count}, {1'b1, exp_count});
   endtask

   initial begin
      repeat (8) @(posedge clock);
      #1;
      check({response.valid, target_select, error_count}, 40'h0);
      @(negedge clock);
      reset = 1'b0;
      t_map();
      t_size();
      t_enable();
      wrap_up();
   end
endmodule
